// ---- hw/pcfg_header_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pcfg_defines.svh"
module pcfg_header_decode #(
    parameter int IMPL_BYTES = 4096,
    parameter int F1_DWORDS  = `PCFG_F1_DWORDS
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 cfgReq,
    input  wire logic                 cfgWrite,
    input  wire logic                 cfgFunc,
    input  wire logic [7:0]           cfgAddr,
    input  wire pcfg_pkg::pcfg_word_t cfgWdata,
    input  wire logic [3:0]           cfgByteEn,
    output logic                      cfgAck,
    output pcfg_pkg::pcfg_word_t      cfgRdata,
    input  wire logic                 memReq,
    input  wire logic                 memWrite,
    input  wire pcfg_pkg::pcfg_word_t memAddr,
    input  wire pcfg_pkg::pcfg_word_t memWdata,
    output logic                      devselN,
    output logic                      memDone,
    output pcfg_pkg::pcfg_word_t      memRdata,
    output logic                      beReq,
    output logic                      beWrite,
    output logic [19:0]               beAddr,
    output pcfg_pkg::pcfg_word_t      beWdata,
    input  wire logic                 beAck,
    input  wire pcfg_pkg::pcfg_word_t beRdata,
    input  wire logic                 parityErr
);

    localparam logic [20:0] IMPL_LIM = 21'(IMPL_BYTES);
    localparam int          F1_AW    = $clog2(F1_DWORDS);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic dwHit(input logic [7:0] addr, input logic [7:0] off);
        dwHit = (addr[7:2] == off[7:2]);
    endfunction : dwHit

    function automatic logic [7:0] laneMerge(input logic [7:0] old, input logic [7:0] val, input logic en);
        laneMerge = en ? val : old;
    endfunction : laneMerge

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic                   [11:0] baseFf;
    logic                   [7:0]  intLineFf;
    logic                          memEnFf;
    logic                          parErrFf;
    pcfg_pkg::pcfg_mstate_t        mstateFf;
    pcfg_pkg::pcfg_word_t          fn0RdFf;
    logic                          selF1Ff;
    logic                          cfgAckFf;
    logic                          beReqFf;
    logic                          beWriteFf;
    logic                   [19:0] beAddrFf;
    pcfg_pkg::pcfg_word_t          beWdataFf;
    logic                          memDoneFf;
    pcfg_pkg::pcfg_word_t          memRdataFf;
    pcfg_pkg::pcfg_word_t          f1Rd;

    logic inHdr;
    logic wr0;
    logic rd0;
    logic f1Wr;
    logic f1RdEn;
    logic claim;
    logic implHit;

    assign inHdr   = ({1'b0, cfgAddr} < `PCFG_HDR_BYTES);
    assign wr0     = cfgReq && cfgWrite && !cfgFunc;
    assign rd0     = cfgReq && !cfgWrite && !cfgFunc;
    assign f1Wr    = cfgReq && cfgWrite && cfgFunc && inHdr;
    assign f1RdEn  = cfgReq && !cfgWrite && cfgFunc && inHdr;
    assign implHit = ({1'b0, memAddr[19:0]} < IMPL_LIM);

    // Window match, nonzero upper bits, enable, sequencer free
    assign claim   = memReq && (mstateFf == pcfg_pkg::PCFG_MS_IDLE) && memEnFf
                     && (baseFf != `PCFG_BASE_RST) && (memAddr[31:20] == baseFf);
    assign devselN = !claim;

    // ----------------------------------------------------------------
    // Writable configuration fields
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            baseFf <= `PCFG_BASE_RST;
        end else if (wr0 && dwHit(cfgAddr, `PCFG_OFF_BASE)) begin
            baseFf[11:4] <= laneMerge(baseFf[11:4], cfgWdata[31:24], cfgByteEn[3]);
            if (cfgByteEn[2]) begin
                baseFf[3:0] <= cfgWdata[23:20];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            intLineFf <= `PCFG_INTLINE_RST;
        end else if (wr0 && dwHit(cfgAddr, `PCFG_OFF_INTINFO)) begin
            intLineFf <= laneMerge(intLineFf, cfgWdata[7:0], cfgByteEn[0]);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            memEnFf <= 1'b0;
        end else if (wr0 && dwHit(cfgAddr, `PCFG_OFF_CMDSTAT) && cfgByteEn[0]) begin
            memEnFf <= cfgWdata[`PCFG_MEMEN_BIT];
        end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            parErrFf <= 1'b0;
        end else if (parityErr) begin
            parErrFf <= 1'b1;
        end else if (wr0 && dwHit(cfgAddr, `PCFG_OFF_CMDSTAT) && cfgByteEn[3]
                     && cfgWdata[`PCFG_PARERR_BIT]) begin
            parErrFf <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration read path
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fn0RdFf <= `PCFG_WORD_ZERO;
        end else if (rd0) begin
            fn0RdFf <= `PCFG_WORD_ZERO;
            if (dwHit(cfgAddr, `PCFG_OFF_CMDSTAT)) begin
                fn0RdFf[`PCFG_PARERR_BIT] <= parErrFf;
                fn0RdFf[`PCFG_MEMEN_BIT]  <= memEnFf;
            end else if (dwHit(cfgAddr, `PCFG_OFF_BASE)) begin
                fn0RdFf[31:`PCFG_BASE_LSB] <= baseFf;
            end else if (dwHit(cfgAddr, `PCFG_OFF_INTINFO)) begin
                fn0RdFf[`PCFG_MAXLAT_LSB +: 8]  <= `PCFG_MAXLAT_VAL;
                fn0RdFf[`PCFG_MINGNT_LSB +: 8]  <= `PCFG_MINGNT_VAL;
                fn0RdFf[`PCFG_INTPIN_LSB +: 8]  <= `PCFG_INTPIN_VAL;
                fn0RdFf[`PCFG_INTLINE_LSB +: 8] <= intLineFf;
            end
        end else begin
            fn0RdFf <= `PCFG_WORD_ZERO;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfgAckFf <= 1'b0;
            selF1Ff  <= 1'b0;
        end else begin
            cfgAckFf <= cfgReq;
            selF1Ff  <= cfgReq && !cfgWrite && cfgFunc;
        end
    end

    // Second function header storage
    pcfg_dword_mem #(
        .WORDS (F1_DWORDS),
        .AW    (F1_AW)
    ) u_f1_mem (
        .mclk   (mclk),
        .rstn   (rstn),
        .wrEn   (f1Wr),
        .wrIdx  (cfgAddr[F1_AW+1:2]),
        .wrData (cfgWdata),
        .wrBe   (cfgByteEn),
        .rdEn   (f1RdEn),
        .rdIdx  (cfgAddr[F1_AW+1:2]),
        .rdData (f1Rd)
    );

    assign cfgAck   = cfgAckFf;
    assign cfgRdata = selF1Ff ? f1Rd : fn0RdFf;

    // ----------------------------------------------------------------
    // Memory-cycle sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mstateFf <= pcfg_pkg::PCFG_MS_IDLE;
        end else begin
            case (mstateFf)
                pcfg_pkg::PCFG_MS_IDLE: begin
                    if (claim) begin
                        mstateFf <= implHit ? pcfg_pkg::PCFG_MS_BACK : pcfg_pkg::PCFG_MS_ZERO;
                    end
                end
                pcfg_pkg::PCFG_MS_BACK: begin
                    if (beAck) begin
                        mstateFf <= pcfg_pkg::PCFG_MS_IDLE;
                    end
                end
                pcfg_pkg::PCFG_MS_ZERO: begin
                    mstateFf <= pcfg_pkg::PCFG_MS_IDLE;
                end
                default: begin
                    mstateFf <= pcfg_pkg::PCFG_MS_IDLE;
                end
            endcase
        end
    end

    // Backend request only for implemented locations
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            beReqFf   <= 1'b0;
            beWriteFf <= 1'b0;
            beAddrFf  <= 20'h0_0000;
            beWdataFf <= `PCFG_WORD_ZERO;
        end else begin
            beReqFf <= claim && implHit;
            if (claim && implHit) begin
                beWriteFf <= memWrite;
                beAddrFf  <= memAddr[19:0];
                beWdataFf <= memWdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            memDoneFf  <= 1'b0;
            memRdataFf <= `PCFG_WORD_ZERO;
        end else if (mstateFf == pcfg_pkg::PCFG_MS_BACK && beAck) begin
            memDoneFf  <= 1'b1;
            memRdataFf <= beWriteFf ? `PCFG_WORD_ZERO : beRdata;
        end else if (mstateFf == pcfg_pkg::PCFG_MS_ZERO) begin
            memDoneFf  <= 1'b1;
            memRdataFf <= `PCFG_WORD_ZERO;
        end else begin
            memDoneFf  <= 1'b0;
            memRdataFf <= `PCFG_WORD_ZERO;
        end
    end

    assign beReq    = beReqFf;
    assign beWrite  = beWriteFf;
    assign beAddr   = beAddrFf;
    assign beWdata  = beWdataFf;
    assign memDone  = memDoneFf;
    assign memRdata = memRdataFf;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_claim;
        memReq && mstateFf == pcfg_pkg::PCFG_MS_IDLE && memEnFf && baseFf != 12'h000
        && memAddr[31:20] == baseFf |-> !devselN;
    endproperty
    a_claim: assert property (p_claim) else $error("Matching memory cycle not claimed");

    property p_noclaim_off;
        !memEnFf || baseFf == 12'h000 |-> devselN;
    endproperty
    a_noclaim_off: assert property (p_noclaim_off) else $error("Claimed while disabled");

    property p_unimpl_zero;
        !devselN && !implHit |=> !beReq ##1 memDone && memRdata == 32'h0000_0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented access not zero");

    property p_base_low;
        rd0 && dwHit(cfgAddr, 8'h10) |=> cfgAck && cfgRdata[19:0] == 20'h0_0000
        && cfgRdata[31:20] == $past(baseFf);
    endproperty
    a_base_low: assert property (p_base_low) else $error("Base low bits not zero");

    property p_rsvd;
        rd0 && cfgAddr >= 8'h14 && cfgAddr <= 8'h3B |=> cfgRdata == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("Reserved dword not zero");

    property p_info;
        rd0 && dwHit(cfgAddr, 8'h3C) |=> cfgRdata[31:8] == 24'h0F_0001 && cfgRdata[7:0] == $past(intLineFf);
    endproperty
    a_info: assert property (p_info) else $error("Latency grant pin wrong");

    property p_intline;
        (wr0 && dwHit(cfgAddr, 8'h3C) && cfgByteEn[0]) ##1 !cfgReq ##1 (rd0 && dwHit(cfgAddr, 8'h3C))
        |=> cfgRdata[7:0] == $past(cfgWdata[7:0], 3);
    endproperty
    a_intline: assert property (p_intline) else $error("Interrupt line not kept");

    property p_devdep;
        cfgReq && !cfgWrite && !inHdr |=> cfgRdata == 32'h0000_0000;
    endproperty
    a_devdep: assert property (p_devdep) else $error("Dependent region not zero");

    property p_rr;
        wr0 && dwHit(cfgAddr, 8'h04) && cfgByteEn[3] && !parityErr
        |=> parErrFf == ($past(parErrFf) && !$past(cfgWdata[31]));
    endproperty
    a_rr: assert property (p_rr) else $error("Status clear wrong");

    property p_f1;
        (f1Wr && cfgByteEn == 4'hF) ##1 !cfgReq ##1 (f1RdEn && cfgAddr[7:2] == $past(cfgAddr[7:2], 2))
        |=> cfgRdata == $past(cfgWdata, 3);
    endproperty
    a_f1: assert property (p_f1) else $error("Second function word lost");

    c_claim_back: cover property (claim && implHit ##1 beReq ##[1:8] memDone);
    c_claim_zero: cover property (claim && !implHit ##2 memDone);
    c_f1_read:    cover property (f1RdEn ##1 cfgAck);
    c_rr_clear:   cover property (parErrFf ##1 !parErrFf);

endmodule : pcfg_header_decode
`default_nettype wire

// ---- hw/pcfg_defines.svh ----
`ifndef PCFG_DEFINES_SVH
`define PCFG_DEFINES_SVH

// ----------------------------------------------------------------
// Configuration offsets and sizes (bytes; function 1 size in dwords)
// ----------------------------------------------------------------
`define PCFG_OFF_CMDSTAT    8'h04
`define PCFG_OFF_BASE       8'h10
`define PCFG_OFF_RSVD_FIRST 8'h14
`define PCFG_OFF_RSVD_LAST  8'h38
`define PCFG_OFF_INTINFO    8'h3C
`define PCFG_HDR_BYTES      9'h040
`define PCFG_F1_DWORDS      16

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCFG_BASE_LSB       20
`define PCFG_MAXLAT_LSB     24
`define PCFG_MINGNT_LSB     16
`define PCFG_INTPIN_LSB     8
`define PCFG_INTLINE_LSB    0
`define PCFG_MEMEN_BIT      1
`define PCFG_PARERR_BIT     31

// ----------------------------------------------------------------
// Fixed and reset values
// ----------------------------------------------------------------
`define PCFG_MAXLAT_VAL     8'h0F
`define PCFG_MINGNT_VAL     8'h00
`define PCFG_INTPIN_VAL     8'h01
`define PCFG_BASE_RST       12'h000
`define PCFG_INTLINE_RST    8'h00
`define PCFG_WORD_ZERO      32'h0000_0000

`endif

// ---- hw/pcfg_pkg.sv ----
`default_nettype none
package pcfg_pkg;

    typedef logic [31:0] pcfg_word_t;

    // Memory-cycle sequencer, Gray along idle -> backend -> idle
    typedef enum logic [1:0] {
        PCFG_MS_IDLE = 2'b00,
        PCFG_MS_BACK = 2'b01,
        PCFG_MS_ZERO = 2'b11
    } pcfg_mstate_t;

endpackage : pcfg_pkg
`default_nettype wire

// ---- hw/pcfg_dword_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcfg_dword_mem #(
    parameter int WORDS = 16,
    parameter int AW    = 4
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 wrEn,
    input  wire logic [AW-1:0]        wrIdx,
    input  wire pcfg_pkg::pcfg_word_t wrData,
    input  wire logic [3:0]           wrBe,
    input  wire logic                 rdEn,
    input  wire logic [AW-1:0]        rdIdx,
    output pcfg_pkg::pcfg_word_t      rdData
);

    pcfg_pkg::pcfg_word_t memFf [WORDS];
    pcfg_pkg::pcfg_word_t rdDataFf;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < WORDS; i++) begin
                memFf[i] <= `PCFG_WORD_ZERO;
            end
        end else if (wrEn) begin
            for (int b = 0; b < 4; b++) begin
                if (wrBe[b]) begin
                    memFf[wrIdx][b*8 +: 8] <= wrData[b*8 +: 8];
                end
            end
        end
    end

    // Disabled reads return zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdDataFf <= `PCFG_WORD_ZERO;
        end else begin
            rdDataFf <= rdEn ? memFf[rdIdx] : `PCFG_WORD_ZERO;
        end
    end

    assign rdData = rdDataFf;

endmodule : pcfg_dword_mem
`default_nettype wire

// ---- verif/pcfg_backend_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Window backend: word store behind the claimed memory window
// ----------------------------------------------------------------
module pcfg_backend_model (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [3:0]  delayCycles,
    input  wire logic        beReq,
    input  wire logic        beWrite,
    input  wire logic [19:0] beAddr,
    input  wire logic [31:0] beWdata,
    output logic             beAck,
    output logic [31:0]      beRdata
);
    logic [31:0] store [64] = '{default: 32'h0000_0000};
    logic        ackQ       = 1'b0;
    logic [31:0] rdQ        = 32'h0000_0000;

    assign beAck   = ackQ;
    assign beRdata = rdQ;

    // Answer each request after a chosen number of idle cycles
    always @(posedge mclk) begin
        if (rstn && beReq) begin
            repeat (delayCycles) @(posedge mclk);
            #1;
            if (beWrite) store[beAddr[7:2]] = beWdata;
            rdQ  = beWrite ? 32'h0000_0000 : store[beAddr[7:2]];
            ackQ = 1'b1;
            @(posedge mclk);
            #1;
            ackQ = 1'b0;
            rdQ  = ~rdQ;
        end else begin
            #1;
            // Data not valid: keep it moving
            rdQ = ~rdQ;
        end
    end
endmodule : pcfg_backend_model
`default_nettype wire

// ---- verif/pcfg_header_decode_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcfg_header_decode_tb;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        cfgReq = 1'b0, cfgWrite = 1'b0, cfgFunc = 1'b0;
    logic [7:0]  cfgAddr = 8'h00;
    logic [31:0] cfgWdata = 32'h0000_0000, cfgRdata;
    logic [3:0]  cfgByteEn = 4'h0;
    logic        cfgAck;
    logic        memReq = 1'b0, memWrite = 1'b0, parityErr = 1'b0;
    logic [31:0] memAddr = 32'h0000_0000, memWdata = 32'h0000_0000, memRdata;
    logic        devselN, memDone, beReq, beWrite, beAck;
    logic [19:0] beAddr;
    logic [31:0] beWdata, beRdata;
    logic [3:0]  delayCycles = 4'h0;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          lat;

    always #20 mclk = ~mclk;

    pcfg_header_decode #(.IMPL_BYTES(256), .F1_DWORDS(16)) pcfg_header_decode_inst (
        .mclk(mclk), .rstn(rstn), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgFunc(cfgFunc),
        .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgByteEn(cfgByteEn), .cfgAck(cfgAck),
        .cfgRdata(cfgRdata), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
        .memWdata(memWdata), .devselN(devselN), .memDone(memDone), .memRdata(memRdata),
        .beReq(beReq), .beWrite(beWrite), .beAddr(beAddr), .beWdata(beWdata),
        .beAck(beAck), .beRdata(beRdata), .parityErr(parityErr));

    pcfg_backend_model pcfg_backend_model_inst (
        .mclk(mclk), .rstn(rstn), .delayCycles(delayCycles), .beReq(beReq),
        .beWrite(beWrite), .beAddr(beAddr), .beWdata(beWdata), .beAck(beAck), .beRdata(beRdata));

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic cfg_acc(input logic wr, input logic f, input logic [7:0] a,
                           input logic [31:0] d, input logic [3:0] be, input logic [31:0] exp);
        @(posedge mclk);
        #1;
        cfgReq = 1'b1; cfgWrite = wr; cfgFunc = f; cfgAddr = a; cfgWdata = d; cfgByteEn = be;
        @(posedge mclk);
        #1;
        cfgReq = 1'b0;
        chk({31'h0, cfgAck}, 32'h0000_0001);
        if (!wr) chk(cfgRdata, exp);
    endtask : cfg_acc

    task automatic cfg_wr(input logic f, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        cfg_acc(1'b1, f, a, d, be, 32'h0000_0000);
    endtask : cfg_wr

    task automatic cfg_rd(input logic f, input logic [7:0] a, input logic [31:0] exp);
        cfg_acc(1'b0, f, a, 32'h0000_0000, 4'h0, exp);
    endtask : cfg_rd

    task automatic mem_acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                           input logic claim, input logic [31:0] exp, output int n);
        @(posedge mclk);
        #1;
        memReq = 1'b1; memWrite = wr; memAddr = a; memWdata = d;
        #1;
        chk({31'h0, devselN}, {31'h0, ~claim});
        @(posedge mclk);
        #1;
        memReq = 1'b0;
        n = 1;
        while (memDone !== 1'b1 && n < 30) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({31'h0, memDone}, {31'h0, claim});
        if (claim) chk(memRdata, exp);
    endtask : mem_acc

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        #(40 * 20000);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge mclk);
        #1;
        rstn = 1'b1;
        cfg_rd(1'b0, 8'h10, 32'h0000_0000);
        cfg_rd(1'b0, 8'h3C, 32'h0F00_0100);
        cfg_rd(1'b0, 8'h04, 32'h0000_0000);
        // No claim while base is zero, even with the window enabled
        cfg_wr(1'b0, 8'h04, 32'h0000_0002, 4'hF);
        mem_acc(1'b0, 32'h0000_0010, 32'h0, 1'b0, 32'h0, lat);
        cfg_wr(1'b0, 8'h04, 32'h0000_0000, 4'hF);
        cfg_wr(1'b0, 8'h10, 32'hFFFF_FFFF, 4'hF);
        cfg_rd(1'b0, 8'h10, 32'hFFF0_0000);
        cfg_wr(1'b0, 8'h10, 32'hABC5_5555, 4'hF);
        cfg_rd(1'b0, 8'h10, 32'hABC0_0000);
        cfg_wr(1'b0, 8'h3C, 32'hFFFF_FFAB, 4'hF);
        cfg_rd(1'b0, 8'h3C, 32'h0F00_01AB);
        for (int a = 'h14; a <= 'h38; a += 4) begin
            cfg_wr(1'b0, a[7:0], 32'hFFFF_FFFF, 4'hF);
            cfg_rd(1'b0, a[7:0], 32'h0000_0000);
        end
        for (int a = 'h40; a <= 'hFC; a += 'h3C) begin
            cfg_wr(1'b0, a[7:0], 32'hFFFF_FFFF, 4'hF);
            cfg_rd(1'b0, a[7:0], 32'h0000_0000);
            cfg_wr(1'b1, a[7:0], 32'hFFFF_FFFF, 4'hF);
            cfg_rd(1'b1, a[7:0], 32'h0000_0000);
        end
        for (int i = 0; i < 16; i++) cfg_wr(1'b1, 8'(i * 4), 32'h5A00_0000 | 32'(i), 4'hF);
        for (int i = 0; i < 16; i++) cfg_rd(1'b1, 8'(i * 4), 32'h5A00_0000 | 32'(i));
        cfg_wr(1'b1, 8'h0C, 32'h1122_3344, 4'hF);
        cfg_rd(1'b1, 8'h0C, 32'h1122_3344);
        cfg_wr(1'b1, 8'h0C, 32'hAAAA_AAAA, 4'h5);
        cfg_rd(1'b1, 8'h0C, 32'h11AA_33AA);
        cfg_rd(1'b0, 8'h10, 32'hABC0_0000);
        // Status bit: set by a parity pulse, cleared only by a one
        @(posedge mclk);
        #1;
        parityErr = 1'b1;
        @(posedge mclk);
        #1;
        parityErr = 1'b0;
        cfg_rd(1'b0, 8'h04, 32'h8000_0000);
        cfg_wr(1'b0, 8'h04, 32'h0000_0002, 4'hF);
        cfg_rd(1'b0, 8'h04, 32'h8000_0002);
        cfg_wr(1'b0, 8'h04, 32'h8000_0000, 4'h8);
        cfg_rd(1'b0, 8'h04, 32'h0000_0002);
        // Memory window decode
        mem_acc(1'b0, 32'hABD0_0010, 32'h0, 1'b0, 32'h0, lat);
        mem_acc(1'b0, 32'hABC0_1000, 32'h0, 1'b1, 32'h0, lat);
        chk(32'(lat), 32'h0000_0002);
        mem_acc(1'b1, 32'hABCF_FFFC, 32'hDEAD_BEEF, 1'b1, 32'h0, lat);
        mem_acc(1'b0, 32'hABCF_FFFC, 32'h0, 1'b1, 32'h0, lat);
        mem_acc(1'b1, 32'hABC0_0010, 32'hCAFE_0123, 1'b1, 32'h0, lat);
        mem_acc(1'b0, 32'hABC0_0010, 32'h0, 1'b1, 32'hCAFE_0123, lat);
        delayCycles = 4'h6;
        mem_acc(1'b0, 32'hABC0_0010, 32'h0, 1'b1, 32'hCAFE_0123, lat);
        delayCycles = 4'h0;
        cfg_wr(1'b0, 8'h04, 32'h0000_0000, 4'hF);
        mem_acc(1'b0, 32'hABC0_0010, 32'h0, 1'b0, 32'h0, lat);
        // Second reset returns writable fields to zero
        @(posedge mclk);
        #1;
        rstn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rstn = 1'b1;
        cfg_rd(1'b0, 8'h10, 32'h0000_0000);
        cfg_rd(1'b0, 8'h3C, 32'h0F00_0100);
        final_report();
    end
endmodule : pcfg_header_decode_tb
`default_nettype wire
